// file: wer_pkg.sv
package wer_pkg;

  // ==========================================================
  // Register indices; one word each, so the byte address is four times the index
  localparam int          IDX_EVENT_SELECT    = 0;
  localparam int          IDX_STATE_ENABLE    = 1;
  localparam int          IDX_IRQ_ENABLE_LOW  = 2;
  localparam logic [11:0] ADDR_EVENT_SELECT   = 12'(4 * IDX_EVENT_SELECT);
  localparam logic [11:0] ADDR_STATE_ENABLE   = 12'(4 * IDX_STATE_ENABLE);
  localparam logic [11:0] ADDR_IRQ_ENABLE_LOW = 12'(4 * IDX_IRQ_ENABLE_LOW);
  localparam logic [11:0] ADDR_CONFIG         = 12'h00C;
  localparam logic [11:0] ADDR_STATUS         = 12'h010;

  // ==========================================================
  // Field layout
  localparam int SEL_WIDTH          = 5;
  localparam int NUM_EVENTS         = 32;
  localparam int BIT_PULSE_S3       = 3;
  localparam int BIT_PULSE_S45      = 2;
  localparam int BIT_PWRON_S3       = 1;
  localparam int BIT_PWRON_S45      = 0;
  localparam int BIT_PULSE_MODE     = 0;
  localparam int BIT_EXT_STATE_SEL  = 1;
  localparam int STATUS_IRQ_BASE    = 16;

  // ==========================================================
  // Reset values and masks
  localparam logic [7:0] RESET_BYTE     = 8'h00;
  localparam logic [4:0] RESET_SELECT   = 5'h00;
  localparam logic [7:0] CLASS_A_MASK   = 8'h0F;
  localparam logic [7:0] CLASS_B_MASK   = 8'h03;
  // Events of class B hold power-on enables only
  localparam logic [31:0] CLASS_B_EVENTS = 32'h0E00_0000;

  // ==========================================================
  // Timing
  localparam int PULSE_TIME_NS  = 16;
  localparam int CLK_PERIOD_NS  = 8;
  localparam int PULSE_CYCLES   = (PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] PULSE_COUNT = 4'(PULSE_CYCLES);

  // ==========================================================
  // Sleep groups and pulse states
  typedef enum logic [1:0] {
    WER_AWAKE,
    WER_SUSPEND_RAM_GROUP,
    WER_SOFT_OFF_GROUP
  } wer_sleep_type;

  typedef enum logic [1:0] {
    WER_PULSE_IDLE,
    WER_PULSE_HIGH
  } wer_pulse_type;

endpackage

// file: wer_wakeup_event_routing.sv
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
module wer_wakeup_event_routing (
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   clk_en,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Events and state
  input  wire logic [31:0]            event_active,
  input  wire logic [31:0]            general_event_status,
  input  wire wer_pkg::wer_sleep_type sleep_state,
  // Outputs
  output logic                        power_button_pulse_out,
  output logic                        main_power_on_out,
  output logic                        irq_request
);
  import wer_pkg::*;

  // ==========================================================
  // Registers
  logic [SEL_WIDTH-1:0] wake_event_select_field;
  logic [7:0]           wake_state_enable [NUM_EVENTS];
  logic [7:0]           event_irq_enable_low;
  logic                 pulse_output_mode;
  logic                 external_state_select;
  logic [31:0]          event_prev;
  logic [3:0]           pulse_cnt;
  wer_pulse_type        pulse_state;

  logic                 wr_strobe;
  logic                 rd_strobe;
  logic                 addr_ok;
  logic [31:0]          event_rise;
  logic                 want_pulse;
  logic                 want_power_on;
  logic [31:0]          next_prdata;

  // Mask of implemented bits for an event, by its class
  function automatic logic [7:0] class_mask(input logic [SEL_WIDTH-1:0] sel);
    class_mask = CLASS_B_EVENTS[sel] ? CLASS_B_MASK : CLASS_A_MASK;
  endfunction

  // ==========================================================
  // APB decode
  assign addr_ok = (paddr == ADDR_EVENT_SELECT) || (paddr == ADDR_STATE_ENABLE) ||
                   (paddr == ADDR_IRQ_ENABLE_LOW) || (paddr == ADDR_CONFIG) ||
                   (paddr == ADDR_STATUS);
  // Zero wait: the access phase ends at its first edge
  assign wr_strobe = clk_en && psel && penable && pwrite && addr_ok && pstrb[0];
  assign rd_strobe = clk_en && psel && !penable && !pwrite;

  always_comb begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      ADDR_EVENT_SELECT:   next_prdata[SEL_WIDTH-1:0] = wake_event_select_field;
      ADDR_STATE_ENABLE:   next_prdata[7:0] = wake_state_enable[wake_event_select_field];
      ADDR_IRQ_ENABLE_LOW: next_prdata[7:0] = event_irq_enable_low;
      ADDR_CONFIG: begin
        next_prdata[BIT_PULSE_MODE]    = pulse_output_mode;
        next_prdata[BIT_EXT_STATE_SEL] = external_state_select;
      end
      ADDR_STATUS: begin
        next_prdata[0] = power_button_pulse_out;
        next_prdata[1] = main_power_on_out;
        next_prdata[2] = irq_request;
      end
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b1;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= 1'b1;
      if (rd_strobe) begin
        prdata <= next_prdata;
      end
      // Unmapped addresses answer with an error in the access phase
      if (psel && !penable) begin
        pslverr <= !addr_ok;
      end
    end
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_event_select_field <= RESET_SELECT;
      event_irq_enable_low    <= RESET_BYTE;
      pulse_output_mode       <= 1'b0;
      external_state_select   <= 1'b0;
    end else if (wr_strobe) begin
      case (paddr)
        ADDR_EVENT_SELECT:   wake_event_select_field <= pwdata[SEL_WIDTH-1:0];
        ADDR_IRQ_ENABLE_LOW: event_irq_enable_low <= pwdata[7:0];
        ADDR_CONFIG: begin
          pulse_output_mode     <= pwdata[BIT_PULSE_MODE];
          external_state_select <= pwdata[BIT_EXT_STATE_SEL];
        end
        default: ;
      endcase
    end
  end

  // One entry per event; only the selected one is written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_EVENTS; i++) begin
        wake_state_enable[i] <= RESET_BYTE;
      end
    end else if (wr_strobe && paddr == ADDR_STATE_ENABLE) begin
      // Reserved bits stay zero
      wake_state_enable[wake_event_select_field] <=
        pwdata[7:0] & class_mask(wake_event_select_field);
    end
  end

  // ==========================================================
  // Event routing
  // Rising edges only, so a held event does not retrigger
  assign event_rise = event_active & ~event_prev;

  always_comb begin
    want_pulse    = 1'b0;
    want_power_on = 1'b0;
    for (int i = 0; i < NUM_EVENTS; i++) begin
      if (event_rise[i]) begin
        if (sleep_state == WER_SUSPEND_RAM_GROUP) begin
          want_pulse    = want_pulse    | wake_state_enable[i][BIT_PULSE_S3];
          want_power_on = want_power_on | wake_state_enable[i][BIT_PWRON_S3];
        end
        if (sleep_state == WER_SOFT_OFF_GROUP) begin
          want_pulse    = want_pulse    | wake_state_enable[i][BIT_PULSE_S45];
          want_power_on = want_power_on | wake_state_enable[i][BIT_PWRON_S45];
        end
      end
    end
    want_pulse    = want_pulse && !pulse_output_mode;
    want_power_on = want_power_on && !external_state_select;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_prev <= 32'h0000_0000;
    end else if (clk_en) begin
      event_prev <= event_active;
    end
  end

  // Pulse stretcher: fixed width so a one-cycle event is still visible
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_state            <= WER_PULSE_IDLE;
      pulse_cnt              <= 4'h0;
      power_button_pulse_out <= 1'b0;
    end else if (clk_en) begin
      case (pulse_state)
        WER_PULSE_IDLE: begin
          if (want_pulse) begin
            pulse_state            <= WER_PULSE_HIGH;
            pulse_cnt              <= PULSE_COUNT - 4'h1;
            power_button_pulse_out <= 1'b1;
          end
        end
        WER_PULSE_HIGH: begin
          if (pulse_cnt == 4'h0) begin
            pulse_state            <= WER_PULSE_IDLE;
            power_button_pulse_out <= 1'b0;
          end else begin
            pulse_cnt <= pulse_cnt - 4'h1;
          end
        end
        default: begin
          pulse_state            <= WER_PULSE_IDLE;
          power_button_pulse_out <= 1'b0;
        end
      endcase
    end
  end

  // Main power stays on once switched until sleep_state returns to WER_AWAKE
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_power_on_out <= 1'b0;
    end else if (clk_en) begin
      if (want_power_on) begin
        main_power_on_out <= 1'b1;
      end else if (sleep_state == WER_AWAKE) begin
        main_power_on_out <= 1'b0;
      end
    end
  end

  // ==========================================================
  // IRQ routing of status bits 16-23
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_request <= 1'b0;
    end else if (clk_en) begin
      // Bit 7 power, 6 sleep, 5..3 keyboard, 2 mouse, 1..0 ring
      irq_request <= |(general_event_status[STATUS_IRQ_BASE +: 8] &
                       event_irq_enable_low);
    end
  end

  // ==========================================================
  // Checks
  a_irq_gating: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en |=> irq_request == |($past(general_event_status[23:16]) & $past(event_irq_enable_low)))
    else $error("irq request not gated by enables");

  a_irq_bit7: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && event_irq_enable_low == 8'h80 && general_event_status[23]) |=> irq_request)
    else $error("power button irq missing");

  a_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && event_irq_enable_low == 8'h00) |=> !irq_request)
    else $error("irq raised while all disabled");

  a_pulse_mode: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && pulse_output_mode && !power_button_pulse_out) |=> !power_button_pulse_out)
    else $error("pulse while pulse mode set");

  a_pulse_s3: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && !pulse_output_mode && !power_button_pulse_out && sleep_state == WER_SUSPEND_RAM_GROUP
     && event_rise[wake_event_select_field]
     && wake_state_enable[wake_event_select_field][BIT_PULSE_S3]) |=> power_button_pulse_out)
    else $error("suspend pulse missing");

  a_pulse_width: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && $rose(power_button_pulse_out)) |=> (clk_en ##0 power_button_pulse_out) or !clk_en)
    else $error("pulse shorter than two cycles");

  a_ext_select: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && external_state_select && !main_power_on_out) |=> !main_power_on_out)
    else $error("power on with external select");

  a_power_s45: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && !external_state_select && sleep_state == WER_SOFT_OFF_GROUP
     && event_rise[wake_event_select_field]
     && wake_state_enable[wake_event_select_field][BIT_PWRON_S45]) |=> main_power_on_out)
    else $error("soft-off power on missing");

  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    wake_state_enable[wake_event_select_field][7:4] == 4'h0)
    else $error("reserved state enable bits set");

  a_pulse_s45: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && !pulse_output_mode && !power_button_pulse_out && sleep_state == WER_SOFT_OFF_GROUP
     && event_rise[wake_event_select_field]
     && wake_state_enable[wake_event_select_field][BIT_PULSE_S45]) |=> power_button_pulse_out)
    else $error("soft-off pulse missing");

  a_power_s3: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && !external_state_select && sleep_state == WER_SUSPEND_RAM_GROUP
     && event_rise[wake_event_select_field]
     && wake_state_enable[wake_event_select_field][BIT_PWRON_S3]) |=> main_power_on_out)
    else $error("suspend power on missing");

  // An awake system must never see a stray power button press
  a_pulse_awake: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && sleep_state == WER_AWAKE && !power_button_pulse_out) |=> !power_button_pulse_out)
    else $error("pulse while awake");

  a_pulse_no_rise: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && event_rise == 32'h0 && !power_button_pulse_out) |=> !power_button_pulse_out)
    else $error("pulse without event edge");

  a_pulse_ends: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && pulse_state == WER_PULSE_HIGH && pulse_cnt == 4'h0) |=> !power_button_pulse_out)
    else $error("pulse longer than its width");

  a_power_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && main_power_on_out && sleep_state != WER_AWAKE) |=> main_power_on_out)
    else $error("main power dropped while asleep");

  a_power_no_rise: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && event_rise == 32'h0 && !main_power_on_out) |=> !main_power_on_out)
    else $error("main power without event edge");

  // Clock enable low must freeze every output
  a_frozen_outs: assert property (@(posedge pclk) disable iff (!presetn)
    !clk_en |=> $stable(power_button_pulse_out) && $stable(main_power_on_out)
                && $stable(irq_request))
    else $error("outputs moved while frozen");

  a_pready_high: assert property (@(posedge pclk) disable iff (!presetn)
    pready)
    else $error("pready low");

  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && psel && !penable && !addr_ok) |=> pslverr)
    else $error("no error on unmapped address");

  a_mapped_ok: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && psel && !penable && addr_ok) |=> !pslverr)
    else $error("error on mapped address");

  a_irq_en_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_strobe && paddr == ADDR_IRQ_ENABLE_LOW) |=> event_irq_enable_low == $past(pwdata[7:0]))
    else $error("irq enable write lost");

  a_irq_en_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_strobe && paddr == ADDR_IRQ_ENABLE_LOW) |=> prdata == {24'h0, $past(event_irq_enable_low)})
    else $error("irq enable read wrong");

  a_select_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_strobe && paddr == ADDR_EVENT_SELECT)
    |=> wake_event_select_field == $past(pwdata[SEL_WIDTH-1:0]))
    else $error("event select write lost");

  a_select_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_strobe && paddr == ADDR_EVENT_SELECT) |=> prdata == 32'($past(wake_event_select_field)))
    else $error("event select read wrong");

  // Class B events have no pulse enables at all
  a_class_b_bits: assert property (@(posedge pclk) disable iff (!presetn)
    CLASS_B_EVENTS[wake_event_select_field] |-> wake_state_enable[wake_event_select_field][3:2] == 2'b00)
    else $error("pulse enable set on class B event");

  a_irq_bit6: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && event_irq_enable_low[6] && general_event_status[22]) |=> irq_request)
    else $error("sleep button irq missing");

  a_irq_bit5: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && event_irq_enable_low[5] && general_event_status[21]) |=> irq_request)
    else $error("keyboard event three irq missing");

  a_irq_bit4: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && event_irq_enable_low[4] && general_event_status[20]) |=> irq_request)
    else $error("keyboard event two irq missing");

  a_irq_bit3: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && event_irq_enable_low[3] && general_event_status[19]) |=> irq_request)
    else $error("keyboard event one irq missing");

  a_irq_bit2: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && event_irq_enable_low[2] && general_event_status[18]) |=> irq_request)
    else $error("mouse irq missing");

  a_irq_bit1: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && event_irq_enable_low[1] && general_event_status[17]) |=> irq_request)
    else $error("ring port two irq missing");

  a_irq_bit0: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && event_irq_enable_low[0] && general_event_status[16]) |=> irq_request)
    else $error("ring port one irq missing");

endmodule

// file: wer_wakeup_event_routing_test.sv
`timescale 1ns/1ps
module wer_wakeup_event_routing_test;
  import wer_pkg::*;
  // ==========================================================
  // Stimulus and observed signals
  logic          pclk = 1'b0;
  logic          presetn = 1'b0;
  logic          clk_en = 1'b1;
  logic          psel = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite = 1'b0;
  logic [11:0]   paddr = 12'h000;
  logic [31:0]   pwdata = 32'h0;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic [31:0]   event_active = 32'h0;
  logic [31:0]   general_event_status = 32'h0;
  wer_sleep_type sleep_state = WER_AWAKE;
  logic          power_button_pulse_out;
  logic          main_power_on_out;
  logic          irq_request;
  int            bad_count = 0;
  int            n_tests = 0;
  logic [31:0]   rdat;
  logic          rerr;

  always #4 pclk = ~pclk;

  wer_wakeup_event_routing i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .event_active(event_active),
    .general_event_status(general_event_status), .sleep_state(sleep_state),
    .power_button_pulse_out(power_button_pulse_out), .main_power_on_out(main_power_on_out),
    .irq_request(irq_request));

  // ==========================================================
  // Shared tasks
  task automatic finish_test();
    $display("Checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask

  // One edge of gap first, so a release is never followed by a setup in the same step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdat, rerr);
    chk("write error", 32'h0, 32'(rerr));
  endtask

  task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rdat, rerr);
    chk(what, exp, rdat);
  endtask

  // Counts pulse cycles over a window longer than any pulse, so width is checked too
  task automatic step(input logic [7:0] cfg, input logic [7:0] en, input wer_sleep_type st,
                      input int exp_p, input logic exp_m);
    int cnt;
    cnt = 0;
    wr(ADDR_CONFIG, 32'(cfg));
    wr(ADDR_STATE_ENABLE, 32'(en));
    @(posedge pclk);
    sleep_state <= st;
    @(posedge pclk);
    event_active[3] <= 1'b1;
    repeat (8) begin
      @(posedge pclk);
      #1;
      if (power_button_pulse_out === 1'b1) cnt++;
    end
    chk("pulse cycles", 32'(exp_p), 32'(cnt));
    chk("main power", 32'(exp_m), 32'(main_power_on_out));
    @(posedge pclk);
    event_active[3] <= 1'b0;
    sleep_state <= WER_AWAKE;
    repeat (3) @(posedge pclk);
    #1;
    chk("main power awake", 32'h0, 32'(main_power_on_out));
  endtask

  // ==========================================================
  // Scenarios
  task automatic test_regs();
    chk("outputs reset", 32'h0, 32'({power_button_pulse_out, main_power_on_out, irq_request}));
    rd("select reset", ADDR_EVENT_SELECT, 32'h0);
    rd("state enable reset", ADDR_STATE_ENABLE, 32'h0);
    rd("irq enable reset", ADDR_IRQ_ENABLE_LOW, 32'h0);
    rd("config reset", ADDR_CONFIG, 32'h0);
    wr(ADDR_STATE_ENABLE, 32'hFF);
    rd("class A mask", ADDR_STATE_ENABLE, 32'h0F);
    wr(ADDR_EVENT_SELECT, 32'h19);
    rd("class B reset", ADDR_STATE_ENABLE, 32'h0);
    wr(ADDR_STATE_ENABLE, 32'hFF);
    rd("class B mask", ADDR_STATE_ENABLE, 32'h03);
    wr(ADDR_EVENT_SELECT, 32'h0);
    rd("event zero kept", ADDR_STATE_ENABLE, 32'h0F);
    wr(ADDR_STATE_ENABLE, 32'h00);
    apb(1'b0, 12'h014, 32'h0, rdat, rerr);
    chk("unmapped error", 32'h1, 32'(rerr));
    $display("test_regs done");
  endtask

  task automatic test_irq();
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_IRQ_ENABLE_LOW, 32'(1) << i);
      rd("irq enable", ADDR_IRQ_ENABLE_LOW, 32'(1) << i);
      @(posedge pclk);
      general_event_status <= ~(32'(1) << (STATUS_IRQ_BASE + i));
      repeat (3) @(posedge pclk);
      #1;
      chk("irq masked", 32'h0, 32'(irq_request));
      @(posedge pclk);
      general_event_status <= 32'(1) << (STATUS_IRQ_BASE + i);
      repeat (3) @(posedge pclk);
      #1;
      chk("irq enabled", 32'h1, 32'(irq_request));
      rd("status irq", ADDR_STATUS, 32'h4);
    end
    @(posedge pclk);
    general_event_status <= 32'h0;
    $display("test_irq done");
  endtask

  // Enable status stays clear throughout, so actions cannot lean on it
  task automatic test_route();
    wr(ADDR_EVENT_SELECT, 32'h3);
    step(8'h00, 8'h0F, WER_SUSPEND_RAM_GROUP, PULSE_CYCLES, 1'b1);
    step(8'h00, 8'h08, WER_SOFT_OFF_GROUP, 0, 1'b0);
    step(8'h00, 8'h04, WER_SOFT_OFF_GROUP, PULSE_CYCLES, 1'b0);
    step(8'h00, 8'h04, WER_SUSPEND_RAM_GROUP, 0, 1'b0);
    step(8'h00, 8'h02, WER_SUSPEND_RAM_GROUP, 0, 1'b1);
    step(8'h00, 8'h01, WER_SOFT_OFF_GROUP, 0, 1'b1);
    step(8'h00, 8'h01, WER_SUSPEND_RAM_GROUP, 0, 1'b0);
    step(8'h01, 8'h0F, WER_SOFT_OFF_GROUP, 0, 1'b1);
    step(8'h02, 8'h0F, WER_SUSPEND_RAM_GROUP, PULSE_CYCLES, 1'b0);
    step(8'h00, 8'h00, WER_SUSPEND_RAM_GROUP, 0, 1'b0);
    $display("test_route done");
  endtask

  // Clock enable low must hold the IRQ output still
  task automatic test_freeze();
    wr(ADDR_IRQ_ENABLE_LOW, 32'h80);
    @(posedge pclk);
    clk_en <= 1'b0;
    general_event_status <= 32'(1) << (STATUS_IRQ_BASE + 7);
    repeat (3) @(posedge pclk);
    #1;
    chk("irq frozen", 32'h0, 32'(irq_request));
    @(posedge pclk);
    clk_en <= 1'b1;
    repeat (3) @(posedge pclk);
    #1;
    chk("irq thawed", 32'h1, 32'(irq_request));
    @(posedge pclk);
    general_event_status <= 32'h0;
    wr(ADDR_IRQ_ENABLE_LOW, 32'h00);
    $display("test_freeze done");
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    test_regs();
    test_irq();
    test_freeze();
    test_route();
    finish_test();
  end
endmodule
